//--- core/ddps_top.sv
`timescale 1ns/10ps
module ddps_top (
  input  wire logic                i_core_clk,
  input  wire logic                i_rst,
  input  wire logic                i_cfg_mode,
  input  wire ddps_pkg::ddps_cfg_req_t i_cfg_req,
  input  wire ddps_pkg::ddps_rate_t    i_rate,
  input  wire logic [1:0]          i_drive_sel,
  output logic [7:0]               o_rdata,
  output logic                     o_rdata_valid,
  output logic [7:0]               o_drive_type,
  output logic                     o_density_out_a,
  output logic                     o_density_out_b
);
  import ddps_pkg::*;

  logic [7:0]  config_index_reg;
  logic [7:0]  test_reserved_reg;
  logic [7:0]  drive_type_select_reg;
  logic [7:0]  rdata_next;
  logic [DDPS_FIELD_W-1:0] field_sel;
  ddps_code_t  code_sel;
  logic        dens_a_next;
  logic        dens_b_next;
  logic        drive_type_bit0;
  logic        drive_type_bit1;

  // index register, loaded only in configuration mode
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      config_index_reg <= DDPS_INDEX_RST;
    end else if (i_cfg_mode && i_cfg_req.index_wr) begin
      config_index_reg <= i_cfg_req.wdata;
    end
  end

  // test register, kept at its reset value by software
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      test_reserved_reg <= DDPS_TEST_RST;
    end else if (i_cfg_mode && i_cfg_req.data_wr && config_index_reg == DDPS_IDX_TEST) begin
      test_reserved_reg <= i_cfg_req.wdata;
    end
  end

  // drive-type table
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      drive_type_select_reg <= DDPS_DRV_TYPE_RST;
    end else if (i_cfg_mode && i_cfg_req.data_wr && config_index_reg == DDPS_IDX_DRV_TYPE) begin
      drive_type_select_reg <= i_cfg_req.wdata;
    end
  end

  // read data decode; reserved and foreign indices read as zero
  always_comb begin
    if (config_index_reg == DDPS_IDX_TEST) begin
      rdata_next = test_reserved_reg;
    end else if (config_index_reg >= DDPS_IDX_RSVD_LO && config_index_reg <= DDPS_IDX_RSVD_HI) begin
      rdata_next = DDPS_RSVD_VAL;
    end else if (config_index_reg == DDPS_IDX_DRV_TYPE) begin
      rdata_next = drive_type_select_reg;
    end else begin
      rdata_next = DDPS_UNMAPPED_VAL;
    end
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata       <= 8'h00;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata_valid <= i_cfg_mode && i_cfg_req.data_rd;
      if (i_cfg_mode && i_cfg_req.data_rd) begin
        o_rdata <= rdata_next;
      end
    end
  end

  // field of the selected drive
  always_comb begin
    field_sel       = drive_type_select_reg[DDPS_FIELD_W*i_drive_sel +: DDPS_FIELD_W];
    drive_type_bit0 = field_sel[DDPS_DT0_POS];
    drive_type_bit1 = field_sel[DDPS_DT1_POS];
    code_sel        = ddps_code_t'({drive_type_bit0, drive_type_bit1});
  end

  // pin mapping per drive-type code
  always_comb begin
    case (code_sel)
      DDPS_DT_DENSITY_SELECT: begin
        dens_a_next = i_rate.density_select;
        dens_b_next = i_rate.rate_bit0;
      end
      DDPS_DT_RATE10: begin
        dens_a_next = i_rate.rate_bit1;
        dens_b_next = i_rate.rate_bit0;
      end
      DDPS_DT_DENSITY_SELECT_INVERTED: begin
        dens_a_next = ~i_rate.density_select;
        dens_b_next = i_rate.rate_bit0;
      end
      default: begin
        dens_a_next = i_rate.rate_bit0;
        dens_b_next = i_rate.rate_bit1;
      end
    endcase
  end

  // registered pin and table outputs
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_density_out_a <= 1'b0;
      o_density_out_b <= 1'b0;
      o_drive_type    <= DDPS_DRV_TYPE_RST;
    end else begin
      o_density_out_a <= dens_a_next;
      o_density_out_b <= dens_b_next;
      o_drive_type    <= drive_type_select_reg;
    end
  end

endmodule

//--- shared/ddps_pkg.sv
package ddps_pkg;

  // configuration space indices
  localparam logic [7:0] DDPS_IDX_TEST      = 8'h11;
  localparam logic [7:0] DDPS_IDX_RSVD_LO   = 8'h12;
  localparam logic [7:0] DDPS_IDX_RSVD_HI   = 8'h1e;
  localparam logic [7:0] DDPS_IDX_DRV_TYPE  = 8'h1f;

  // values after reset, and read values of reserved and unmapped indices
  localparam logic [7:0] DDPS_TEST_RST      = 8'h00;
  localparam logic [7:0] DDPS_RSVD_VAL      = 8'h00;
  localparam logic [7:0] DDPS_DRV_TYPE_RST  = 8'h00;
  localparam logic [7:0] DDPS_INDEX_RST     = 8'h00;
  localparam logic [7:0] DDPS_UNMAPPED_VAL  = 8'h00;

  // drive-type field layout: drive n occupies bits [2n+1:2n]
  localparam int         DDPS_FIELD_W       = 2;
  localparam int         DDPS_NUM_DRIVES    = 4;
  localparam int         DDPS_DT0_POS       = 1;  // higher bit of a field
  localparam int         DDPS_DT1_POS       = 0;  // lower bit of a field

  // drive-type codes written as {drive_type_bit0, drive_type_bit1}
  typedef enum logic [1:0] {
    DDPS_DT_DENSITY_SELECT  = 2'h0,
    DDPS_DT_RATE10  = 2'h1,
    DDPS_DT_DENSITY_SELECT_INVERTED = 2'h2,
    DDPS_DT_RATE01  = 2'h3
  } ddps_code_t;

  // configuration port request
  typedef struct packed {
    logic       index_wr;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] wdata;
  } ddps_cfg_req_t;

  // internal density and rate sources
  typedef struct packed {
    logic density_select;
    logic rate_bit1;
    logic rate_bit0;
  } ddps_rate_t;

endpackage

//--- dv/ddps_drive_model.sv
`timescale 1ns/10ps
module ddps_drive_model (input wire logic i_a, i_b, output logic [1:0] o_seen);
  // drive sees the pin levels only
  assign o_seen = {i_a, i_b};
endmodule

//--- dv/ddps_checker.sv
`timescale 1ns/10ps
module ddps_checker import ddps_pkg::*; (
  input wire logic i_core_clk, i_rst, i_cfg_mode, o_rdata_valid, o_density_out_a, o_density_out_b,
  input wire ddps_cfg_req_t i_cfg_req, input wire ddps_rate_t i_rate, input wire logic [1:0] i_drive_sel,
  input wire logic [7:0] o_rdata, o_drive_type);
  logic [7:0] ix;
  logic [3:0] av;
  logic [1:0] s, f;
  logic p, rq;
  ddps_rate_t r;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // shadow of index, read strobe, drive and sources
  always_ff @(posedge i_core_clk) begin
    {s, r, p, rq} <= {i_drive_sel, i_rate, i_rst, i_cfg_mode && i_cfg_req.data_rd};
    if (i_rst) ix <= 8'h00;
    else if (i_cfg_mode && i_cfg_req.index_wr) ix <= i_cfg_req.wdata;
  end
  // pin a source for each code
  assign f = o_drive_type[2*s +: 2];
  assign av = {r.rate_bit0, !r.density_select, r.rate_bit1, r.density_select};
  sequence rd_s; i_cfg_mode && i_cfg_req.data_rd; endsequence
  rd_gate_a: assert property (o_rdata_valid |-> rq) else $error("stray read valid");
  rsvd_zero_a: assert property (rd_s ##0 ix inside {[8'h12:8'h1e]} |-> ##1 o_rdata_valid && o_rdata == 8'h00)
    else $error("reserved read");
  dtype_rd_a: assert property (rd_s ##0 ix == 8'h1f |-> ##1 o_rdata_valid && o_rdata == o_drive_type)
    else $error("type read");
  pin_a_a: assert property (!p |-> o_density_out_a == av[f]) else $error("pin a");
  pin_b_a: assert property (!p |-> o_density_out_b == (f == 2'h3 ? r.rate_bit1 : r.rate_bit0))
    else $error("pin b");
  inv_code_a: assert property (!p && f == 2'h2 |-> o_density_out_a != r.density_select) else $error("inv");
  hi_field_a: assert property (!p && s == 2'h3 && o_drive_type[7:6] == 2'h0 |-> o_density_out_a == r.density_select)
    else $error("drive 3");
endmodule
bind ddps_top ddps_checker u_chk (.*);

//--- dv/tb.sv
`timescale 1ns/10ps
module tb;
  import ddps_pkg::*;
  logic i_core_clk = 0, i_rst = 1, i_cfg_mode = 1, o_rdata_valid, o_density_out_a, o_density_out_b;
  logic [1:0] i_drive_sel = 0, seen;
  logic [4:0] av;
  logic [7:0] o_rdata, o_drive_type, dt, q[$];
  ddps_cfg_req_t i_cfg_req = '0;
  ddps_rate_t i_rate = '0;
  int failures, n_checks;
  always #5 i_core_clk = ~i_core_clk;
  ddps_top DUT (.*);
  ddps_drive_model u_drv (.i_a(o_density_out_a), .i_b(o_density_out_b), .o_seen(seen));
  task automatic ck(string n, logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // strobe held to the next edge, reads noted
  task automatic op(logic [2:0] s, logic [7:0] d, logic [7:0] e = 8'h00);
    if (s == 3'h1 && i_cfg_mode) q.push_back(e);
    i_cfg_req = {s, d};
    @(posedge i_core_clk) #1;
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // read data against the oldest note
  always @(negedge i_core_clk) if (o_rdata_valid === 1'b1) begin
    if (q.size() == 0) ck("rdata_stray", 8'h01, 8'h00);
    else ck("rdata", o_rdata, q.pop_front());
  end
  // reset, space walk, refusal, pin mapping
  initial begin
    void'($urandom(30));
    repeat (5) @(posedge i_core_clk);
    #1 i_rst = 0;
    for (int i = 8'h11; i < 8'h20; i++) begin
      dt = 8'($urandom);
      op(3'h4, 8'(i));
      op(3'h1, 8'h00, 8'h00);
      op(3'h2, i == 8'h11 ? 8'h00 : dt);
      op(3'h1, 8'h00, i == 8'h1f ? dt : 8'h00);
    end
    i_cfg_mode = 0;
    op(3'h4, 8'h11);
    op(3'h2, ~dt);
    op(3'h1, 8'h00);
    i_cfg_mode = 1;
    op(3'h1, 8'h00, dt);
    for (int k = 0; k < 16; k++) begin
      dt = 8'($urandom);
      dt[2*k[3:2] +: 2] = 2'(k);
      op(3'h2, dt);
      {i_drive_sel, i_rate} = {2'(k >> 2), 3'($urandom)};
      i_cfg_req = '0;
      repeat (2) @(posedge i_core_clk);
      #1 av = {k[1:0] == 2'h3 ? i_rate.rate_bit1 : i_rate.rate_bit0, i_rate.rate_bit0,
        !i_rate.density_select, i_rate.rate_bit1, i_rate.density_select};
      ck("pins", 8'(seen), 8'({av[k[1:0]], av[4]}));
      ck("dtype", o_drive_type, dt);
      op(3'h1, 8'h00, dt);
    end
    i_cfg_req = '0;
    i_rst = 1;
    repeat (2) @(posedge i_core_clk);
    #1 i_rst = 0;
    ck("dtype_rst", o_drive_type, DDPS_DRV_TYPE_RST);
    op(3'h4, 8'h1f);
    op(3'h1, 8'h00, DDPS_DRV_TYPE_RST);
    i_cfg_req = '0;
    repeat (3) @(posedge i_core_clk);
    ck("left", 8'(q.size()), 8'h00);
    final_report;
  end
endmodule
